/* hdl/isl_params.svh */
`ifndef ISL_PARAMS_SVH
`define ISL_PARAMS_SVH
// ----------------------------------------
// Register indices on the plain port
// ----------------------------------------
`define ISL_IDX_CTRL0 3'h0
`define ISL_IDX_CTRL1 3'h1
`define ISL_IDX_DATA 3'h2
`define ISL_IDX_ADDR 3'h3
`define ISL_IDX_TMO 3'h4
// ----------------------------------------
// Control zero fields
// ----------------------------------------
`define ISL_C0_FUNC 7:5
`define ISL_C0_DBC 3:2
`define ISL_C0_EN 1
`define ISL_C0_SPIINC 0
`define ISL_FUNC_RST 3'h7
`define ISL_FUNC_DIV4 3'h0
`define ISL_FUNC_DIV16 3'h1
`define ISL_FUNC_DIV64 3'h2
`define ISL_FUNC_SUB 3'h3
`define ISL_FUNC_TM0 3'h4
`define ISL_FUNC_SPIS 3'h5
`define ISL_FUNC_I2C 3'h6
`define ISL_DBC_NONE 2'h0
`define ISL_DBC_TWO 2'h1
`define ISL_DBC_CNT2 2'h1
`define ISL_DBC_CNT4 2'h3
// ----------------------------------------
// Control one fields
// ----------------------------------------
`define ISL_C1_HTX 4
`define ISL_C1_ACK_TO_SEND 3
`define ISL_C1_WAKE 1
// ----------------------------------------
// Time-out control fields
// ----------------------------------------
`define ISL_TO_EN 7
`define ISL_TO_FLAG 6
`define ISL_TO_PER 5:0
`define ISL_TO_PRE_LAST 5'h1F
// ----------------------------------------
// Misc counts
// ----------------------------------------
`define ISL_BITS_BYTE 4'h8
`define ISL_DIV4_MASK 6'h03
`define ISL_DIV16_MASK 6'h0F
`define ISL_DIV64_MASK 6'h3F
`endif

/* hdl/isl_pkg.sv */
package isl_pkg;
  // Gray coded along address, data and ack path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_RX = 3'h2,
    ST_RX_ACK = 3'h6,
    ST_TX = 3'h7,
    ST_TX_ACK = 3'h5,
    ST_WAIT = 3'h4
  } isl_state_t;
endpackage : isl_pkg

/* hdl/isl_i2c_slave.sv */
`timescale 1ns/10ps
`include "isl_params.svh"
// Function
// - Mode field selects SPI master/slave, I2C, none
// - SPI master bit clock from selected source
// - Debounce field selects none, two, four clocks
// - Disabled module floats pins
// - Enable rise resets flags, keeps control bits
// - Byte done low in transfer, high after
// - Address match flag follows address compare
// - Busy set on START, cleared on STOP
// - Transmit select chooses receiver or transmitter
// - Ack-to-send driven on ninth clock
// - Direction bit captured as read-only flag
// - Address match wakes when wake enabled
// - Received ack flag, reset value one
// - All bus data via shared data register
// - Address register shares SPI second control
// - Bits seven to one hold own address
// - Time-out from sub clock over 32
// - Match stores direction, acks ninth bit
// - Dummy data read releases SCL
module isl_i2c_slave
  import isl_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register port
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  // Rate enables
  input wire logic sub_tick_i,
  input wire logic tm0_match_i,
  // Events
  output logic event_o,
  output logic wake_o,
  output logic spi_bit_tick_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [2:0] function_select;
  logic [1:0] debounce_select;
  logic module_enable, spi_incomplete_flag;
  logic byte_done_flag, addr_match_flag, bus_busy_flag, transmit_select, ack_to_send;
  logic master_read_request, addr_wake_enable, ack_received_n;
  logic [7:0] shift_data_register, own_address_register;
  logic timeout_enable, timeout_flag;
  logic [5:0] timeout_period;
  isl_state_t state;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic [1:0] pin_s1, pin_s2, filt, filt_d;
  logic [4:0] tmo_pre;
  logic [5:0] tmo_cnt;
  logic [5:0] div_cnt;
  logic tm0_half;
  logic wr_c0, wr_c1, wr_data, wr_addr, wr_tmo, rd_data, en_rise;
  logic active, scl, sda, scl_rise, scl_fall, start_det, stop_det;
  logic byte_fall8, ev_match, ev_miss, ev_rx_byte, ev_tx_done, byte_start, tmo_hit, tmo_run;

  // ----------------------------------------
  // Decode and bus events
  // ----------------------------------------
  always_comb
  begin
    wr_c0 = reg_wr_i && reg_addr_i == `ISL_IDX_CTRL0;
    wr_c1 = reg_wr_i && reg_addr_i == `ISL_IDX_CTRL1;
    wr_data = reg_wr_i && reg_addr_i == `ISL_IDX_DATA;
    wr_addr = reg_wr_i && reg_addr_i == `ISL_IDX_ADDR;
    wr_tmo = reg_wr_i && reg_addr_i == `ISL_IDX_TMO;
    rd_data = reg_rd_i && reg_addr_i == `ISL_IDX_DATA;
    en_rise = wr_c0 && reg_wdata_i[`ISL_C0_EN] && !module_enable
              && reg_wdata_i[`ISL_C0_FUNC] == `ISL_FUNC_I2C;
    active = module_enable && function_select == `ISL_FUNC_I2C;
    scl = filt[1];
    sda = filt[0];
    scl_rise = scl && !filt_d[1];
    scl_fall = !scl && filt_d[1];
    start_det = active && scl && filt_d[1] && filt_d[0] && !sda;
    stop_det = active && scl && filt_d[1] && !filt_d[0] && sda;
    byte_fall8 = active && scl_fall && bit_cnt == `ISL_BITS_BYTE;
    ev_match = state == ST_ADDR && byte_fall8
               && shreg[7:1] == own_address_register[7:1];
    ev_miss = state == ST_ADDR && byte_fall8 && !ev_match;
    ev_rx_byte = state == ST_RX && byte_fall8;
    ev_tx_done = active && state == ST_TX_ACK && scl_fall;
    byte_start = active && scl_rise && bit_cnt == 4'h0
                 && (state == ST_ADDR || state == ST_RX || state == ST_TX);
    tmo_run = active && timeout_enable && bus_busy_flag && !scl_rise && !scl_fall;
    tmo_hit = tmo_run && sub_tick_i && tmo_pre == `ISL_TO_PRE_LAST
              && tmo_cnt == timeout_period;
  end

  // ----------------------------------------
  // Input sync and debounce
  // ----------------------------------------
  // First stage feeds only the second; the filter reads stage two
  for (genvar i = 0; i < 2; i++)
  begin : g_pin
    logic [1:0] dcnt;
    logic [1:0] need;
    assign need = (debounce_select == `ISL_DBC_NONE) ? 2'h0 :
                  (debounce_select == `ISL_DBC_TWO) ? `ISL_DBC_CNT2 : `ISL_DBC_CNT4;
    always_ff @(posedge clock_i)
    begin
      if (rst_i)
      begin
        pin_s1[i] <= 1'b1;
        pin_s2[i] <= 1'b1;
        filt[i] <= 1'b1;
        filt_d[i] <= 1'b1;
        dcnt <= 2'h0;
      end
      else
      begin
        pin_s1[i] <= i ? scl_i : sda_i;
        pin_s2[i] <= pin_s1[i];
        filt_d[i] <= filt[i];
        if (need == 2'h0 || pin_s2[i] == filt[i])
        begin
          filt[i] <= pin_s2[i];
          dcnt <= 2'h0;
        end
        else if (dcnt == need)
        begin
          filt[i] <= pin_s2[i];
          dcnt <= 2'h0;
        end
        else
          dcnt <= dcnt + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // Software registers and status flags
  // ----------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      function_select <= `ISL_FUNC_RST;
      debounce_select <= 2'h0;
      module_enable <= 1'b0;
      spi_incomplete_flag <= 1'b0;
      transmit_select <= 1'b0;
      ack_to_send <= 1'b0;
      addr_wake_enable <= 1'b0;
      own_address_register <= 8'h00;
      timeout_enable <= 1'b0;
      timeout_period <= 6'h00;
    end
    else
    begin
      if (wr_c0)
      begin
        function_select <= reg_wdata_i[`ISL_C0_FUNC];
        debounce_select <= reg_wdata_i[`ISL_C0_DBC];
        module_enable <= reg_wdata_i[`ISL_C0_EN];
        spi_incomplete_flag <= reg_wdata_i[`ISL_C0_SPIINC]; // No meaning in I2C mode
      end
      if (wr_c1)
      begin
        transmit_select <= reg_wdata_i[`ISL_C1_HTX]; // Kept across enable rise
        ack_to_send <= reg_wdata_i[`ISL_C1_ACK_TO_SEND];
        addr_wake_enable <= reg_wdata_i[`ISL_C1_WAKE];
      end
      if (wr_addr)
        own_address_register <= reg_wdata_i; // Shared with SPI second control view
      if (wr_tmo)
      begin
        timeout_enable <= reg_wdata_i[`ISL_TO_EN];
        timeout_period <= reg_wdata_i[`ISL_TO_PER];
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i || en_rise)
    begin
      byte_done_flag <= 1'b1;
      addr_match_flag <= 1'b0;
      bus_busy_flag <= 1'b0;
      master_read_request <= 1'b0;
      ack_received_n <= 1'b1;
    end
    else
    begin
      if (byte_start)
        byte_done_flag <= 1'b0;
      if (ev_rx_byte || ev_tx_done)
        byte_done_flag <= 1'b1;
      if (start_det || ev_miss || byte_start)
        addr_match_flag <= 1'b0;
      if (ev_match)
      begin
        addr_match_flag <= 1'b1;
        master_read_request <= shreg[0];
      end
      if (stop_det || tmo_hit || !active)
        bus_busy_flag <= 1'b0;
      if (start_det)
        bus_busy_flag <= 1'b1;
      if (active && state == ST_TX_ACK && scl_rise)
        ack_received_n <= sda;
    end
  end

  // Hardware capture beats a same-cycle software write
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      shift_data_register <= 8'h00;
    else if (ev_rx_byte)
      shift_data_register <= shreg;
    else if (wr_data)
      shift_data_register <= reg_wdata_i;
  end

  // ----------------------------------------
  // Time-out counter
  // ----------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      tmo_pre <= 5'h00;
      tmo_cnt <= 6'h00;
      timeout_flag <= 1'b0;
    end
    else
    begin
      if (!tmo_run || tmo_hit)
      begin
        tmo_pre <= 5'h00;
        tmo_cnt <= 6'h00;
      end
      else if (sub_tick_i)
      begin
        tmo_pre <= tmo_pre + 5'h01; // Sub clock over 32
        if (tmo_pre == `ISL_TO_PRE_LAST)
          tmo_cnt <= tmo_cnt + 6'h01;
      end
      if (wr_tmo)
        timeout_flag <= reg_wdata_i[`ISL_TO_FLAG];
      if (tmo_hit)
        timeout_flag <= 1'b1; // Set wins over clear
    end
  end

  // ----------------------------------------
  // Bus state machine
  // ----------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      bit_cnt <= 4'h0;
      sda_oe_o <= 1'b0;
    end
    else if (!active || stop_det || tmo_hit)
    begin
      state <= ST_IDLE; // Released pins float when disabled
      bit_cnt <= 4'h0;
      sda_oe_o <= 1'b0;
    end
    else if (start_det)
    begin
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe_o <= 1'b0;
    end
    else
    begin
      case (state)
        ST_ADDR, ST_RX:
        begin
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (byte_fall8)
          begin
            if (state == ST_RX)
            begin
              state <= ST_RX_ACK;
              sda_oe_o <= !ack_to_send;
            end
            else if (ev_match)
            begin
              state <= ST_ADDR_ACK;
              sda_oe_o <= 1'b1;
            end
            else
              state <= ST_WAIT;
          end
        end
        ST_ADDR_ACK, ST_RX_ACK:
          if (scl_fall)
          begin
            sda_oe_o <= 1'b0;
            bit_cnt <= 4'h0;
            state <= (state == ST_RX_ACK || !transmit_select) ? ST_RX : ST_TX;
          end
        ST_TX:
        begin
          if (bit_cnt == 4'h0 && !scl)
          begin
            shreg <= shift_data_register;
            sda_oe_o <= !shift_data_register[7];
          end
          if (scl_rise)
            bit_cnt <= bit_cnt + 4'h1;
          else if (byte_fall8)
          begin
            sda_oe_o <= 1'b0;
            state <= ST_TX_ACK;
          end
          else if (scl_fall && bit_cnt != 4'h0)
          begin
            shreg <= {shreg[6:0], 1'b0};
            sda_oe_o <= !shreg[6];
          end
        end
        ST_TX_ACK:
          if (scl_fall)
          begin
            bit_cnt <= 4'h0;
            state <= ack_received_n ? ST_WAIT : ST_TX;
          end
        ST_IDLE, ST_WAIT:
          state <= state;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Clock stretch and event outputs
  // ----------------------------------------
  // Holding SCL until software reads or writes the data register prevents overrun
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      scl_oe_o <= 1'b0;
    else if (ev_match || ev_rx_byte || (ev_tx_done && !ack_received_n))
      scl_oe_o <= 1'b1;
    else if (rd_data || wr_data || !active || stop_det || tmo_hit)
      scl_oe_o <= 1'b0;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      event_o <= 1'b0;
      wake_o <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      event_o <= ev_match || ev_rx_byte || ev_tx_done;
      wake_o <= ev_match && addr_wake_enable;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // SPI master bit clock enable
  // ----------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      div_cnt <= 6'h00;
      tm0_half <= 1'b0;
      spi_bit_tick_o <= 1'b0;
    end
    else
    begin
      div_cnt <= div_cnt + 6'h01;
      if (tm0_match_i)
        tm0_half <= !tm0_half;
      case (function_select)
        `ISL_FUNC_DIV4: spi_bit_tick_o <= module_enable && (div_cnt & `ISL_DIV4_MASK) == `ISL_DIV4_MASK;
        `ISL_FUNC_DIV16: spi_bit_tick_o <= module_enable && (div_cnt & `ISL_DIV16_MASK) == `ISL_DIV16_MASK;
        `ISL_FUNC_DIV64: spi_bit_tick_o <= module_enable && div_cnt == `ISL_DIV64_MASK;
        `ISL_FUNC_SUB: spi_bit_tick_o <= module_enable && sub_tick_i;
        `ISL_FUNC_TM0: spi_bit_tick_o <= module_enable && tm0_match_i && tm0_half;
        default: spi_bit_tick_o <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      case (reg_addr_i)
        `ISL_IDX_CTRL0: reg_rdata_o <= {function_select, 1'b0, debounce_select, module_enable, spi_incomplete_flag};
        `ISL_IDX_CTRL1: reg_rdata_o <= {byte_done_flag, addr_match_flag, bus_busy_flag, transmit_select,
                                        ack_to_send, master_read_request, addr_wake_enable, ack_received_n};
        `ISL_IDX_DATA: reg_rdata_o <= shift_data_register;
        `ISL_IDX_ADDR: reg_rdata_o <= own_address_register;
        `ISL_IDX_TMO: reg_rdata_o <= {timeout_enable, timeout_flag, timeout_period};
        default: reg_rdata_o <= 8'h00;
      endcase
    else
      reg_rdata_o <= 8'h00;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  mode_none_a: assert property (function_select != `ISL_FUNC_I2C |=> !sda_oe_o && !scl_oe_o)
    else $error("pins driven outside I2C mode");
  div_four_a: assert property (spi_bit_tick_o && function_select == `ISL_FUNC_DIV4 && !wr_c0
    |=> !spi_bit_tick_o [*3])
    else $error("divide by four tick spacing wrong");
  debounce_hold_a: assert property ($changed(filt[1]) && debounce_select != `ISL_DBC_NONE
    |-> $past(pin_s2[1]) == filt[1] && $past(pin_s2[1], 2) == filt[1])
    else $error("debounced SCL changed too early");
  disable_float_a: assert property (!module_enable |=> !sda_oe_o && !scl_oe_o)
    else $error("pins driven while disabled");
  enable_flags_a: assert property (en_rise |=> byte_done_flag && !addr_match_flag && !bus_busy_flag
    && ack_received_n && !master_read_request && transmit_select == $past(transmit_select))
    else $error("flags not reset on enable rise");
  byte_done_a: assert property ($rose(byte_done_flag) && !$past(en_rise) |-> event_o
    && ($past(bit_cnt) == `ISL_BITS_BYTE || $past(state) == ST_TX_ACK))
    else $error("byte done set without full byte");
  addr_match_a: assert property ($rose(addr_match_flag) |-> $past(shreg[7:1]) == own_address_register[7:1]
    && master_read_request == $past(shreg[0]))
    else $error("address flag without compare");
  busy_start_a: assert property (start_det && !tmo_hit |=> bus_busy_flag)
    else $error("busy not set on start");
  ack_drive_a: assert property (state == ST_RX && byte_fall8 && !stop_det && !start_det
    |=> sda_oe_o == !$past(ack_to_send))
    else $error("ack bit not driven from ack_to_send");
  tmo_expire_a: assert property ($rose(timeout_flag) && !$past(wr_tmo) |-> $past(tmo_pre) == `ISL_TO_PRE_LAST
    && $past(tmo_cnt) == $past(timeout_period))
    else $error("time-out flag set early");
  stretch_hold_a: assert property ($rose(scl_oe_o) |-> addr_match_flag || byte_done_flag)
    else $error("stretch without event");

  match_c: cover property (ev_match ##[1:1000] rd_data);
  rx_byte_c: cover property (ev_rx_byte);
  tx_done_c: cover property (ev_tx_done && !ack_received_n);
  timeout_c: cover property (tmo_hit);
endmodule : isl_i2c_slave

/* test/isl_bus_master.sv */
`timescale 1ns/10ps
module isl_bus_master
(
  // Clock
  input wire logic clock_i,
  // Wire levels after pull-ups
  input wire logic scl_i,
  input wire logic sda_i,
  // Pull-down drives, high pulls low
  output logic scl_low_o,
  output logic sda_low_o
);
  // ----------------------------------------
  // Bit timing
  // ----------------------------------------
  // Quarter bit covers sync flops plus slowest debounce
  localparam int QTR = 10;
  int stall_count = 0;
  initial
  begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  task automatic qtr();
    repeat (QTR) @(posedge clock_i);
  endtask : qtr
  // Slave may stretch; bounded so a stuck SCL cannot hang us
  task automatic wait_high();
    int n;
    n = 0;
    while (scl_i !== 1'b1 && n < 400)
    begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 400)
      stall_count++;
  endtask : wait_high
  // ----------------------------------------
  // Bus conditions
  // ----------------------------------------
  task automatic start();
    sda_low_o <= 1'b1;
    qtr();
    qtr();
    scl_low_o <= 1'b1;
    qtr();
  endtask : start
  task automatic stop();
    sda_low_o <= 1'b1;
    qtr();
    scl_low_o <= 1'b0;
    wait_high();
    qtr();
    sda_low_o <= 1'b0;
    qtr();
    qtr();
  endtask : stop
  // One clock; data changes only while SCL low
  task automatic bit_clk(input logic b, output logic s);
    sda_low_o <= ~b;
    qtr();
    scl_low_o <= 1'b0;
    wait_high();
    qtr();
    s = sda_i;
    qtr();
    scl_low_o <= 1'b1;
    qtr();
  endtask : bit_clk
  task automatic send(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_clk(d[i], s);
  endtask : send
  task automatic recv(input logic ack_n, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_clk(1'b1, s);
      d[i] = s;
    end
    bit_clk(ack_n, s);
  endtask : recv
endmodule : isl_bus_master

/* test/tb_i2c_slave_interface.sv */
`timescale 1ns/10ps
`include "isl_params.svh"
module tb_i2c_slave_interface;
  localparam logic [2:0] c0 = `ISL_IDX_CTRL0;
  localparam logic [2:0] c1 = `ISL_IDX_CTRL1;
  localparam logic [2:0] dr = `ISL_IDX_DATA;
  localparam logic [2:0] ar = `ISL_IDX_ADDR;
  localparam logic [2:0] tr = `ISL_IDX_TMO;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic sub_tick_i;
  logic tm0_match_i;
  wire [7:0] reg_rdata_o;
  wire scl_o, sda_o, scl_oe_o, sda_oe_o, event_o, wake_o, spi_bit_tick_o, m_scl, m_sda;
  // Open drain: pulled up unless someone pulls low
  wire scl = ~(m_scl | scl_oe_o);
  wire sda = ~(m_sda | sda_oe_o);
  int fail_count = 0;
  int checked = 0;
  int ev = 0;
  int wk = 0;
  int tk = 0;
  always #12.5 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    ev <= ev + int'(event_o === 1'b1);
    wk <= wk + int'(wake_o === 1'b1);
    tk <= tk + int'(spi_bit_tick_o === 1'b1);
  end
  isl_i2c_slave i_dut (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .scl_i(scl), .sda_i(sda), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .sub_tick_i(sub_tick_i), .tm0_match_i(tm0_match_i), .event_o(event_o), .wake_o(wake_o),
    .spi_bit_tick_o(spi_bit_tick_o));
  isl_bus_master i_master (.clock_i(clock_i), .scl_i(scl), .sda_i(sda), .scl_low_o(m_scl),
    .sda_low_o(m_sda));
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    @(posedge clock_i);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(posedge clock_i);
    d = reg_rdata_o;
  endtask : rd
  task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
    logic [7:0] v;
    rd(a, v);
    check(nm, v & m, e);
  endtask : rdc
  task automatic pulses(input int n, input logic s, input logic t);
    repeat (n)
    begin
      sub_tick_i <= s;
      tm0_match_i <= t;
      @(posedge clock_i);
      sub_tick_i <= 1'b0;
      tm0_match_i <= 1'b0;
      @(posedge clock_i);
    end
  endtask : pulses
  task automatic end_of_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // Watchdog, well past the expected run
  // ----------------------------------------
  initial
  begin
    repeat (40000) @(posedge clock_i);
    fail_count++;
    end_of_test();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    logic a;
    logic [7:0] v;
    int n;
    logic [7:0] off [3];
    logic [7:0] dbc [3];
    int tick_exp [5];
    reg_addr_i <= 3'h0;
    reg_wdata_i <= 8'h00;
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    sub_tick_i <= 1'b0;
    tm0_match_i <= 1'b0;
    off = '{8'hE2, 8'hA2, 8'hC0};
    dbc = '{8'hC2, 8'hC6, 8'hCE};
    tick_exp = '{64, 16, 4, 126, 63};
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    rdc(c0, 8'hFF, 8'hE0, "ctrl0 reset");
    rdc(c1, 8'hFF, 8'h81, "ctrl1 reset");
    wr(3'h5, 8'hFF);
    for (int i = 2; i < 6; i++)
      rdc(3'(i), 8'hFF, 8'h00, "reset zero");
    wr(c1, 8'hFF);
    rdc(c1, 8'hFF, 8'h9B, "ctrl1 read-only");
    wr(ar, 8'hB5);
    rdc(ar, 8'hFF, 8'hB5, "own address");
    // Unused mode, SPI slave, disabled: nobody answers
    foreach (off[i])
    begin
      wr(c0, off[i]);
      i_master.start();
      i_master.send(8'hB4);
      i_master.bit_clk(1'b1, a);
      check("silent ack", 8'(a), 8'h01);
      i_master.stop();
    end
    check("silent events", 8'(ev), 8'h00);
    // Master writes, every debounce setting
    foreach (dbc[i])
    begin
      wr(c0, dbc[i]);
      rdc(c0, 8'hFE, dbc[i] & 8'hFE, "ctrl0 mode");
      wr(c1, 8'h00);
      i_master.start();
      rdc(c1, 8'h20, 8'h20, "busy");
      i_master.send(8'hB6);
      i_master.bit_clk(1'b1, a);
      check("other address", 8'(a), 8'h01);
      rdc(c1, 8'h40, 8'h00, "no match");
      i_master.stop();
      rdc(c1, 8'h20, 8'h00, "free");
      n = ev;
      i_master.start();
      i_master.send(8'hB4);
      check("match event", 8'(ev - n), 8'h01);
      rdc(c1, 8'h64, 8'h60, "match flags");
      check("stretch", 8'(scl_oe_o), 8'h01);
      check("address ack", 8'(sda_oe_o), 8'h01);
      rd(dr, v);
      i_master.bit_clk(1'b1, a);
      check("ack addr", 8'(a), 8'h00);
      i_master.send(8'hA5);
      rdc(c1, 8'h80, 8'h80, "byte done");
      rdc(dr, 8'hFF, 8'hA5, "rx data");
      i_master.bit_clk(1'b1, a);
      check("ack data", 8'(a), 8'h00);
      wr(c1, 8'h08);
      i_master.send(8'h3C);
      rdc(dr, 8'hFF, 8'h3C, "rx data 2");
      i_master.bit_clk(1'b1, a);
      check("withheld ack", 8'(a), 8'h01);
      wr(c1, 8'h00);
      i_master.stop();
    end
    // Master reads, wake enabled, then enable toggled mid-transfer
    wr(c1, 8'h02);
    n = wk;
    i_master.start();
    i_master.send(8'hB5);
    check("wake", 8'(wk - n), 8'h01);
    rdc(c1, 8'h04, 8'h04, "read dir");
    wr(c1, 8'h12);
    wr(dr, 8'hC3);
    i_master.bit_clk(1'b1, a);
    check("ack read addr", 8'(a), 8'h00);
    i_master.recv(1'b0, v);
    check("tx data", v, 8'hC3);
    rdc(c1, 8'h81, 8'h80, "master acked");
    wr(dr, 8'h5A);
    i_master.recv(1'b1, v);
    check("tx data 2", v, 8'h5A);
    rdc(c1, 8'h01, 8'h01, "master nacked");
    wr(c1, 8'h1A);
    wr(c0, 8'hC4);
    wr(c0, 8'hC6);
    rdc(c1, 8'hFF, 8'h9B, "re-enable");
    wr(c1, 8'h00);
    i_master.stop();
    // Time-out with SCL held low
    wr(tr, 8'h80);
    i_master.start();
    pulses(31, 1'b1, 1'b0);
    rdc(tr, 8'h40, 8'h00, "early");
    pulses(2, 1'b1, 1'b0);
    rdc(tr, 8'h40, 8'h40, "expired");
    rdc(c1, 8'h20, 8'h00, "dropped");
    wr(tr, 8'h00);
    rdc(tr, 8'hFF, 8'h00, "cleared");
    i_master.stop();
    // SPI master bit rate sources over 256 cycles
    for (int m = 0; m < 5; m++)
    begin
      wr(c0, {3'(m), 5'h02});
      // Skip the edge that still ran the old mode; window is then 256
      @(posedge clock_i);
      n = tk;
      pulses(126, m == 3, m == 4);
      repeat (4) @(posedge clock_i);
      check("spi ticks", 8'(tk - n), 8'(tick_exp[m]));
    end
    check("stalls", 8'(i_master.stall_count), 8'h00);
    check("open drain levels", {6'h00, scl_o, sda_o}, 8'h00);
    end_of_test();
  end
endmodule : tb_i2c_slave_interface
